/* core/pnpc_config_bank.sv */
`timescale 1ns/1ns
module pnpc_config_bank
	import pnpc_pkg::*;
#(
	parameter logic [7:0]  PART_ID    = 8'ha5,   // arbitrary value
	parameter logic [7:0]  REV_ID     = 8'h01,   // arbitrary value
	parameter logic [21:0] TYPE_WMASK = 22'h3fffff
)
(
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         clk_en,
	input  wire logic         port_base_strap,
	input  wire logic         sw_reset,
	input  wire logic         stby_reset,
	input  wire pnpc_io_req_t io_req,
	input  wire logic [10:0]  dev_irq,
	output logic [7:0]        io_rdata,
	output logic              io_ack,
	output pnpc_res_t         res [NUM_BANKS],
	output logic [10:0]       wake_set
);

	// ==========================================
	// state
	logic        strap_s1;
	logic        strap_s2;
	logic [1:0]  strap_cnt;
	logic        base_sel;
	logic [7:0]  index;
	logic [7:0]  bank_sel;
	logic        lock;
	logic [10:0] irq_q;
	pnpc_res_t   cfg [NUM_BANKS];

	// ==========================================
	// strap capture after reset release
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			strap_s1  <= 1'b1;
			strap_s2  <= 1'b1;
			strap_cnt <= 2'h0;
			base_sel  <= 1'b1;
		end
		else if (clk_en)
		begin
			strap_s1 <= port_base_strap;
			strap_s2 <= strap_s1;
			if (strap_cnt != 2'h3)
				strap_cnt <= strap_cnt + 2'h1;
			if (strap_cnt == STRAP_TAKE)
				base_sel <= strap_s2;
		end
	end

	// ==========================================
	// port decode
	// bank number to array slot; top bit set only for assigned numbers
	function automatic logic [4:0] bank_map(input logic [7:0] n);
		if (n < 8'h08)
			return {1'b1, n[3:0]};
		case (n)
			8'h09:   return 5'h18;
			8'h0b:   return 5'h19;
			8'h0c:   return 5'h1a;
			default: return 5'h00;
		endcase
	endfunction

	wire [15:0] port_base = base_sel ? PNPC_BASE_HI : PNPC_BASE_LO;
	wire        hit_idx   = io_req.addr == port_base;
	wire        hit_dat   = io_req.addr == port_base + PNPC_DATA_OFS;
	wire        hit_any   = hit_idx | hit_dat;
	wire        wr_idx    = io_req.wr & hit_idx;
	wire        wr_dat    = io_req.wr & hit_dat;
	wire [4:0]  bmap      = bank_map(bank_sel);
	wire        bank_ok   = bmap[4];
	wire [3:0]  bidx      = bmap[3:0];
	wire        banked    = index >= IDX_BANKED;
	wire        bank_wr   = wr_dat & banked & bank_ok;
	wire        vend_idx  = index >= IDX_VEND;
	// view of the selected bank and its writable irq type bits
	pnpc_res_t  cur;
	assign cur = cfg[bidx];
	wire [1:0]  cur_tmask = TYPE_WMASK[{bidx, 1'b0} +: 2];

	// ==========================================
	// read selection
	function automatic logic [7:0] bank_rd(input pnpc_res_t c,
		input logic [7:0] i);
		case (i)
			IDX_BANKED: return {7'h00, c.active};
			IDX_B0H:    return c.base0[15:8];
			IDX_B0L:    return c.base0[7:0];
			IDX_B1H:    return c.base1[15:8];
			IDX_B1L:    return c.base1[7:0];
			IDX_IRQ:    return {3'h0, c.wake_en, c.irq_num};
			IDX_TYPE:   return {6'h00, c.irq_type};
			IDX_DMA0:   return {5'h00, c.dma0};
			IDX_DMA1:   return {5'h00, c.dma1};
			default:    return RD_UNIMP;
		endcase
	endfunction

	// data-port value: unbanked registers, banked view or the missing-register value
	wire        dma_idx  = (index == IDX_DMA0) | (index == IDX_DMA1);
	wire [7:0]  unimp_rd = dma_idx ? RD_NO_DMA : RD_UNIMP;
	wire [7:0]  bank_val = bank_ok ? bank_rd(cur, index) : unimp_rd;
	wire [7:0]  dat_val  =
		(index == IDX_BANK) ? bank_sel :
		(index == IDX_PART) ? PART_ID :
		(index == IDX_REV)  ? REV_ID :
		(index == IDX_LOCK) ? {7'h00, lock} :
		banked              ? bank_val : unimp_rd;
	wire [7:0]  next_rdata = hit_idx ? index : dat_val;

	// ==========================================
	// host answer, ready from the first edge after reset at 2Eh/2Fh, at strap-low 4Eh/4Fh from the fourth
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			io_ack   <= 1'b0;
			io_rdata <= 8'h00;
		end
		else if (clk_en)
		begin
			io_ack <= (io_req.rd | io_req.wr) & hit_any;
			if (io_req.rd & hit_any)
				io_rdata <= next_rdata;
		end
	end

	// ==========================================
	// unbanked registers
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			index    <= IDX_RST;
			bank_sel <= BANK_RST;
		end
		else if (clk_en)
		begin
			if (sw_reset)
			begin
				index    <= IDX_RST;
				bank_sel <= BANK_RST;
			end
			else if (wr_idx)
				index <= io_req.wdata;
			else if (wr_dat & (index == IDX_BANK))
				bank_sel <= io_req.wdata;
		end
	end

	// ==========================================
	// sticky lock, guards every base address
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			lock <= 1'b0;
		else if (clk_en)
		begin
			if (stby_reset)
				lock <= 1'b0;
			else if (wr_dat & (index == IDX_LOCK) & io_req.wdata[0])
				lock <= 1'b1;
		end
	end

	// ==========================================
	// per-bank registers and attached resources
	genvar g;
	generate
		for (g = 0; g < NUM_BANKS; g++)
		begin : g_bank
			wire       we  = bank_wr & (bidx == 4'(g));
			wire [1:0] tm  = TYPE_WMASK[2*g +: 2];
			wire [1:0] nty = (io_req.wdata[1:0] & tm) | (cfg[g].irq_type & ~tm);

			// configuration storage
			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
					cfg[g] <= RES_RST;
				else if (clk_en)
				begin
					if (sw_reset)
					begin
						cfg[g] <= RES_RST;
						if (lock)
						begin
							cfg[g].base0 <= cfg[g].base0;
							cfg[g].base1 <= cfg[g].base1;
						end
					end
					else if (we)
					begin
						case (index)
							IDX_BANKED: cfg[g].active <= io_req.wdata[0];
							IDX_B0H: if (!lock) cfg[g].base0[15:8] <= io_req.wdata;
							IDX_B0L: if (!lock) cfg[g].base0[7:0] <= io_req.wdata;
							IDX_B1H: if (!lock) cfg[g].base1[15:8] <= io_req.wdata;
							IDX_B1L: if (!lock) cfg[g].base1[7:0] <= io_req.wdata;
							IDX_IRQ:
							begin
								cfg[g].irq_num <= io_req.wdata[3:0];
								cfg[g].wake_en <= io_req.wdata[4];
							end
							IDX_TYPE: cfg[g].irq_type <= nty;
							IDX_DMA0: cfg[g].dma0 <= io_req.wdata[2:0];
							IDX_DMA1: cfg[g].dma1 <= io_req.wdata[2:0];
							default: ;
						endcase
					end
				end
			end

			// resources leave only while active
			always_ff @(posedge clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					res[g]      <= RES_RST;
					irq_q[g]    <= 1'b0;
					wake_set[g] <= 1'b0;
				end
				else if (clk_en)
				begin
					res[g]      <= cfg[g].active ? cfg[g] : RES_RST;
					irq_q[g]    <= dev_irq[g];
					wake_set[g] <= dev_irq[g] & ~irq_q[g] & cfg[g].wake_en;
				end
			end
		end
	endgenerate

	// ==========================================
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	strap_take_a: assert property (
		clk_en && strap_cnt == STRAP_TAKE |=> base_sel == $past(strap_s2))
		else $error("strap not taken into base select");

	index_back_a: assert property (
		clk_en && wr_idx && !sw_reset ##1 clk_en && io_req.rd && hit_idx
		|=> io_rdata == $past(io_req.wdata, 2))
		else $error("index read does not return last write");

	answer_next_a: assert property (
		clk_en && (io_req.rd || io_req.wr) && hit_any |=> io_ack)
		else $error("access not answered next cycle");

	no_dma_read_a: assert property (
		clk_en && io_req.rd && hit_dat && index == IDX_DMA0 && !bank_ok
		|=> io_rdata == RD_NO_DMA)
		else $error("missing dma register not reading 04h");

	bank_select_a: assert property (
		clk_en && !sw_reset && wr_dat && !wr_idx && index == IDX_BANK
		|=> bank_sel == $past(io_req.wdata))
		else $error("bank number not stored");

	reserved_bank_a: assert property (
		clk_en && !sw_reset && !bank_ok |=> $stable(cfg[0]) && $stable(cfg[10]))
		else $error("reserved bank access changed a bank");

	inactive_off_a: assert property (
		clk_en && !cfg[0].active |=> !res[0].active && res[0].dma0 == DMA_NONE)
		else $error("inactive device still attached");

	lock_hold_a: assert property (
		clk_en && lock && !stby_reset
		|=> lock && $stable(cfg[0].base0))
		else $error("lock or guarded base changed");

	soft_reset_a: assert property (
		clk_en && sw_reset |=> !cfg[0].active && !cfg[10].active && index == IDX_RST)
		else $error("software reset left a device active");

	wake_edge_a: assert property (
		clk_en && dev_irq[0] && !irq_q[0] && cfg[0].wake_en |=> wake_set[0])
		else $error("irq assertion did not raise wake");

	// ==========================================
	// port, register and bank field checks, half on the selected bank
	index_write_a: assert property (
		clk_en && wr_idx && !sw_reset |=> index == $past(io_req.wdata))
		else $error("index write not stored");

	miss_no_ack_a: assert property (
		clk_en && !((io_req.rd || io_req.wr) && hit_any) |=> !io_ack)
		else $error("unclaimed access answered");

	bank_read_a: assert property (
		clk_en && io_req.rd && hit_dat && index == IDX_BANK |=> io_rdata == $past(bank_sel))
		else $error("bank number read wrong");

	part_read_a: assert property (
		clk_en && io_req.rd && hit_dat && index == IDX_PART |=> io_rdata == PART_ID)
		else $error("part id read wrong");

	activate_bit_a: assert property (
		clk_en && bank_wr && !sw_reset && index == IDX_BANKED
		|=> cur.active == $past(io_req.wdata[0]))
		else $error("activate bit not stored");

	base_write_a: assert property (
		clk_en && bank_wr && !sw_reset && !lock && index == IDX_B0H
		|=> cur.base0[15:8] == $past(io_req.wdata))
		else $error("base high byte not stored");

	irq_field_a: assert property (
		clk_en && bank_wr && !sw_reset && index == IDX_IRQ
		|=> cur.irq_num == $past(io_req.wdata[3:0]) && cur.wake_en == $past(io_req.wdata[4]))
		else $error("irq number not stored");

	type_mask_a: assert property (
		clk_en && bank_wr && !sw_reset && index == IDX_TYPE
		|=> (cur.irq_type & cur_tmask) == ($past(io_req.wdata[1:0]) & cur_tmask)
		&& (cur.irq_type & ~cur_tmask) == ($past(cur.irq_type) & ~cur_tmask))
		else $error("irq type write ignored the writable mask");

	dma_field_a: assert property (
		clk_en && bank_wr && !sw_reset && index == IDX_DMA0
		|=> cur.dma0 == $past(io_req.wdata[2:0]))
		else $error("dma channel not stored");

	vend_drop_a: assert property (
		clk_en && wr_dat && vend_idx && !sw_reset |=> $stable(cur))
		else $error("vendor index write changed a bank");

	lock_set_a: assert property (
		clk_en && wr_dat && index == IDX_LOCK && io_req.wdata[0] && !stby_reset |=> lock)
		else $error("lock bit not set");

	wake_quiet_a: assert property (
		clk_en && !cfg[5].wake_en |=> !wake_set[5])
		else $error("wake raised without enable");

endmodule

/* core/pnpc_pkg.sv */
// Function
// - strap high puts port pair at 2Eh/2Fh, low at 4Eh/4Fh
// - index port at base is read/write, reads back, resets to 00h
// - data port at base plus one reaches the indexed register
// - indexes 30h and up reach the selected bank, lower ones are shared
// - index 07h holds bank number; host writes only assigned numbers
// - eleven banks: 00h-07h, 09h, 0Bh, 0Ch; other numbers reserved
// - data writes to a missing register are dropped with no effect
// - missing registers read 00h, except 74h/75h which read 04h
// - registers take host accesses right after reset, no wait; strap-low 4Eh/4Fh answers only from the fourth edge
// - reserved bits read 0; host preserves them by read-modify-write
// - bit 0 of index 30h activates the bank's device, bits 7-1 reserved
// - activation attaches resources; config stays reachable while inactive
// - 60h/61h hold first base high/low, 62h/63h the second base
// - index 70h bits 3-0 pick IRQ 1-15, zero means none
// - index 70h bit 4 lets IRQ assertion raise the wake status bit
// - index 71h bit 1 polarity, bit 0 edge/level; fixed bits read-only
// - 74h/75h bits 2-0 pick DMA 0-3, 4 means none, 5-7 reserved
// - indexes F0h-FFh reserved for function-specific options
// - unbanked 20h part id and 27h revision id are readable
// - standby power-up reset clears locks and standby defaults
// - main power-up or hardware reset resamples strap, clears locks
// - software reset defaults registers, deactivates all, bases to 00h; here bases keep their value while lock is set
// - a set lock bit freezes itself and its guarded bits until power-up
// - inactive devices ignore runtime accesses and give no answer
package pnpc_pkg;

	// ==========================================
	// port placement
	localparam logic [15:0] PNPC_BASE_HI  = 16'h002e;
	localparam logic [15:0] PNPC_BASE_LO  = 16'h004e;
	localparam logic [15:0] PNPC_DATA_OFS = 16'h0001;

	// ==========================================
	// indexes
	localparam logic [7:0] IDX_RST    = 8'h00;
	localparam logic [7:0] IDX_BANK   = 8'h07;
	localparam logic [7:0] IDX_PART   = 8'h20;
	localparam logic [7:0] IDX_REV    = 8'h27;
	localparam logic [7:0] IDX_LOCK   = 8'h29;
	localparam logic [7:0] IDX_BANKED = 8'h30;
	localparam logic [7:0] IDX_B0H    = 8'h60;
	localparam logic [7:0] IDX_B0L    = 8'h61;
	localparam logic [7:0] IDX_B1H    = 8'h62;
	localparam logic [7:0] IDX_B1L    = 8'h63;
	localparam logic [7:0] IDX_IRQ    = 8'h70;
	localparam logic [7:0] IDX_TYPE   = 8'h71;
	localparam logic [7:0] IDX_DMA0   = 8'h74;
	localparam logic [7:0] IDX_DMA1   = 8'h75;
	localparam logic [7:0] IDX_VEND   = 8'hf0;

	// ==========================================
	// values and counts
	localparam int         NUM_BANKS   = 11;
	localparam logic [7:0] BANK_RST    = 8'h00;
	localparam logic [2:0] DMA_NONE    = 3'h4;
	localparam logic [7:0] RD_UNIMP    = 8'h00;
	localparam logic [7:0] RD_NO_DMA   = 8'h04;
	localparam logic [1:0] STRAP_TAKE  = 2'h2;

	// ==========================================
	// carriers
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} pnpc_io_req_t;

	typedef struct packed {
		logic        active;
		logic [15:0] base0;
		logic [15:0] base1;
		logic [3:0]  irq_num;
		logic        wake_en;
		logic [1:0]  irq_type;
		logic [2:0]  dma0;
		logic [2:0]  dma1;
	} pnpc_res_t;

	localparam pnpc_res_t RES_RST = '{active: 1'b0, base0: 16'h0000,
		base1: 16'h0000, irq_num: 4'h0, wake_en: 1'b0, irq_type: 2'h0,
		dma0: DMA_NONE, dma1: DMA_NONE};

endpackage

/* test/pnpc_host_model.sv */
`timescale 1ns/1ns
// ==========================================
// host side: single-cycle strobes at the index/data port pair
module pnpc_host_model
	import pnpc_pkg::*;
(
	input  wire logic         clk,
	input  wire logic [7:0]   io_rdata,
	input  wire logic         io_ack,
	output pnpc_io_req_t      io_req
);
	initial io_req = '0;

	// strobe for one cycle, then take ack and read data in the answer cycle
	task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic ack);
		@(posedge clk);
		#1 io_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		#1 io_req = '0;
		ack = io_ack;
		q = io_rdata;
	endtask

	// write then read the same port on back-to-back cycles
	task automatic wr_rd(input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		#1 io_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		#1 io_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		#1 io_req = '0;
		q = io_rdata;
	endtask
endmodule

/* test/pnpc_tb.sv */
`timescale 1ns/1ns
module tb
	import pnpc_pkg::*;
;
	localparam logic [7:0] ID_PART = 8'h5c; // arbitrary value
	localparam logic [7:0] ID_REV  = 8'h03; // arbitrary value
	logic         clk        = 1'b0;
	logic         rst_b      = 1'b0;
	logic         clk_en     = 1'b1;
	logic         strap      = 1'b1;
	logic         sw_reset   = 1'b0;
	logic         stby_reset = 1'b0;
	logic [10:0]  dev_irq    = '0;
	logic [15:0]  base       = PNPC_BASE_HI;
	pnpc_io_req_t io_req;
	logic [7:0]   io_rdata;
	logic         io_ack;
	pnpc_res_t    res [NUM_BANKS];
	logic [10:0]  wake_set;
	int           errors     = 0;
	int           tests_run  = 0;

	always #5 clk = ~clk;

	// ==========================================
	// design and host
	pnpc_config_bank #(.PART_ID(ID_PART), .REV_ID(ID_REV)) DUT (.clk(clk), .rst_b(rst_b),
		.clk_en(clk_en), .port_base_strap(strap), .sw_reset(sw_reset),
		.stby_reset(stby_reset), .io_req(io_req), .dev_irq(dev_irq),
		.io_rdata(io_rdata), .io_ack(io_ack), .res(res), .wake_set(wake_set));
	pnpc_host_model host (.clk(clk), .io_rdata(io_rdata), .io_ack(io_ack), .io_req(io_req));

	// ==========================================
	// helpers
	task check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task stop_test;
		if (errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task tick;
		@(posedge clk);
		#1;
	endtask

	task acc(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
		logic k;
		host.xfer(w, a, d, q, k);
		check(k, 1'b1);
	endtask

	task cfg_wr(input logic [7:0] i, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, base, i, q);
		acc(1'b1, base + PNPC_DATA_OFS, d, q);
	endtask

	task cfg_rd(input logic [7:0] i, output logic [7:0] q);
		acc(1'b1, base, i, q);
		acc(1'b0, base + PNPC_DATA_OFS, 8'h00, q);
	endtask

	// ==========================================
	// scenarios
	task t_index;
		logic [7:0] q;
		acc(1'b0, base, 8'h00, q);
		check(q, 8'h00);
		acc(1'b1, base, 8'h9c, q);
		acc(1'b0, base, 8'h00, q);
		check(q, 8'h9c);
		host.wr_rd(base, 8'h3c, q);
		check(q, 8'h3c);
	endtask

	task t_banks;
		logic [7:0] q;
		cfg_wr(IDX_BANK, 8'h03);
		cfg_rd(IDX_BANK, q);
		check(q, 8'h03);
		cfg_wr(IDX_BANKED, 8'hff);
		cfg_wr(IDX_B0H, 8'h12);
		cfg_wr(IDX_B0L, 8'h34);
		cfg_wr(IDX_B1L, 8'h56);
		tick;
		check(res[3].active, 1'b1);
		check(res[3].base0, 16'h1234);
		check(res[3].base1, 16'h0056);
		cfg_rd(IDX_BANKED, q);
		check(q, 8'h01);
		cfg_wr(IDX_BANK, 8'h0c);
		cfg_rd(IDX_B0H, q);
		check(q, 8'h00);
		cfg_wr(IDX_B0H, 8'h77);
		cfg_rd(IDX_B0H, q);
		check(q, 8'h77);
		check(res[10], RES_RST);
		cfg_rd(IDX_PART, q);
		check(q, ID_PART);
		cfg_rd(IDX_REV, q);
		check(q, ID_REV);
	endtask

	// every number 00h-0ch gets its own tag byte; reserved ones keep nothing
	task t_bank_map;
		logic [7:0] q;
		for (int n = 0; n < 13; n++)
		begin
			cfg_wr(IDX_BANK, 8'(n));
			cfg_wr(IDX_B1H, 8'h80 | 8'(n));
		end
		for (int n = 0; n < 13; n++)
		begin
			cfg_wr(IDX_BANK, 8'(n));
			cfg_rd(IDX_B1H, q);
			check(q, (n != 8 && n != 10) ? 8'h80 | 8'(n) : 8'h00);
		end
	endtask

	task t_missing;
		logic [7:0] q;
		cfg_wr(IDX_BANK, 8'h08);
		cfg_rd(IDX_DMA1, q);
		check(q, RD_NO_DMA);
		cfg_rd(IDX_DMA0, q);
		check(q, RD_NO_DMA);
		cfg_wr(IDX_BANK, 8'h09);
		cfg_wr(8'h40, 8'h5a);
		cfg_rd(8'h40, q);
		check(q, RD_UNIMP);
		cfg_wr(IDX_VEND, 8'hff);
		cfg_rd(IDX_VEND, q);
		check(q, 8'h00);
		cfg_rd(IDX_DMA0, q);
		check(q, 8'h04);
	endtask

	task t_irq;
		logic [7:0] q;
		cfg_wr(IDX_BANK, 8'h03);
		cfg_wr(IDX_IRQ, 8'hff);
		cfg_wr(IDX_TYPE, 8'h03);
		cfg_wr(IDX_DMA0, 8'h02);
		tick;
		check(res[3].irq_num, 4'hf);
		check(res[3].wake_en, 1'b1);
		check(res[3].irq_type, 2'h3);
		check(res[3].dma0, 3'h2);
		cfg_rd(IDX_IRQ, q);
		check(q, 8'h1f);
		cfg_wr(IDX_BANK, 8'h00);
		cfg_wr(IDX_IRQ, 8'h10);
		// banks 0, 3 and 5 raise, only 0 and 3 have wake enabled
		dev_irq = 11'h029;
		tick;
		check(wake_set, 11'h009);
		tick;
		check(wake_set, 11'h000);
		dev_irq = '0;
	endtask

	task t_lock;
		logic [7:0] q;
		// bank 0 is selected here and its first base is still at reset
		cfg_wr(IDX_LOCK, 8'h01);
		cfg_rd(IDX_LOCK, q);
		check(q, 8'h01);
		cfg_wr(IDX_B0H, 8'h99);
		cfg_rd(IDX_B0H, q);
		check(q, 8'h00);
		stby_reset = 1'b1;
		tick;
		stby_reset = 1'b0;
		cfg_wr(IDX_B0H, 8'h99);
		cfg_rd(IDX_B0H, q);
		check(q, 8'h99);
	endtask

	task t_swreset;
		logic [7:0] q;
		sw_reset = 1'b1;
		tick;
		sw_reset = 1'b0;
		tick;
		check(res[3], RES_RST);
		acc(1'b0, base, 8'h00, q);
		check(q, IDX_RST);
		cfg_rd(IDX_BANK, q);
		check(q, BANK_RST);
		cfg_wr(IDX_BANK, 8'h03);
		cfg_rd(IDX_B0H, q);
		check(q, 8'h00);
	endtask

	// a frozen block neither answers nor takes a write
	task t_freeze;
		logic [7:0] q;
		logic       k;
		tick;
		clk_en = 1'b0;
		host.xfer(1'b1, base, 8'h55, q, k);
		check(k, 1'b0);
		clk_en = 1'b1;
		acc(1'b0, base, 8'h00, q);
		check(q, IDX_B0H);
	endtask

	task t_strap;
		logic [7:0] q;
		logic       k;
		strap = 1'b0;
		rst_b = 1'b0;
		tick;
		rst_b = 1'b1;
		repeat (4) tick;
		base = PNPC_BASE_LO;
		host.xfer(1'b1, PNPC_BASE_HI, 8'h07, q, k);
		check(k, 1'b0);
		acc(1'b0, base, 8'h00, q);
		check(q, 8'h00);
	endtask

	// ==========================================
	// main sequence and watchdog
	initial
	begin
		repeat (2) @(posedge clk);
		#1 rst_b = 1'b1;
		t_index;
		t_banks;
		t_bank_map;
		t_missing;
		t_irq;
		t_lock;
		t_swreset;
		t_freeze;
		t_strap;
		stop_test;
	end

	initial
	begin
		#50000;
		errors++;
		stop_test;
	end
endmodule
